// ==== include/pinfn_pkg.sv ====
// types of the pin function block
// assumes nothing; types only
package pinfn_pkg;

   typedef enum logic [1:0] {
      BUS_OWN = 2'h0,
      BUS_WAIT = 2'h1,
      BUS_GRANTED = 2'h3,
      BUS_RELEASE = 2'h2
   } bus_state_type;

   typedef enum logic [1:0] {
      SPACE_PROG = 2'h0,
      SPACE_DATA = 2'h1,
      SPACE_BYTE = 2'h2,
      SPACE_IO = 2'h3
   } space_type;

   typedef struct packed {
      logic [4:0] ctrl;
      logic [7:0] dir;
      logic [8:0] outv;
      logic [5:0] mask;
      logic [3:0] strap;
      bus_state_type bus;
      logic acc;
      logic done;
      logic refused;
      logic rd_n;
      logic wr_n;
      logic [4:0] sel_n;
      logic [13:0] addr;
      logic [13:0] addr_oe;
      logic [23:0] dout;
      logic [23:0] doe;
      logic [23:0] rdata;
      logic [5:0] irq;
      logic vec_valid;
      logic [2:0] vec_idx;
      logic [13:0] vec_addr;
      logic [31:0] prdata;
      logic [4:0] sp_o;
      logic [4:0] sp_oe;
      logic [4:0] sp_in;
      logic fi;
   } pin_state_type;

endpackage

// ==== include/pinfn_regs.svh ====
// offsets, fields, reset values, pin masks
// assumes bare-name include; byte offsets
`ifndef PINFN_REGS_SVH
`define PINFN_REGS_SVH

// register offsets
`define PF_CTRL_OFF 8'h00
`define PF_DIR_OFF 8'h04
`define PF_OUT_OFF 8'h08
`define PF_PIN_OFF 8'h0C
`define PF_MASK_OFF 8'h10
`define PF_PEND_OFF 8'h14
`define PF_MODE_OFF 8'h18
`define PF_BUS_OFF 8'h1C

// control fields
`define PF_CTRL_IRQC_EDGE 0
`define PF_CTRL_SP_ALT 1
`define PF_CTRL_GO 2
`define PF_CTRL_SPA_EDGE 3
`define PF_CTRL_SPB_EDGE 4

// reset values
`define PF_CTRL_RST 5'h00
`define PF_DIR_RST 8'h00
`define PF_OUT_RST 9'h000
`define PF_MASK_RST 6'h00
`define PF_SEL_IDLE 5'h1F

// strap and serial pin positions
`define PF_STRAP_C 2
`define PF_SP_IRQ_A 0
`define PF_SP_IRQ_B 1
`define PF_SP_FLAG_IN 2
`define PF_SP_FLAG_OUT 3
`define PF_SP_CLK 4
`define PF_OUT_SP_FLAG 8

// select strobe bit positions
`define PF_SEL_PROG 0
`define PF_SEL_DATA 1
`define PF_SEL_IO 2
`define PF_SEL_BYTE 3
`define PF_SEL_COMB 4

// pad enables per mode
`define PF_AOE_FULL 14'h3FFF
`define PF_AOE_HOST 14'h0001
`define PF_DOE_ALL 24'hFFFFFF
`define PF_DOE_HOST 24'hFFFF00
`define PF_DOE_PAGE 24'hFF0000

// interrupt vectors, index 0 highest priority
`define PF_VEC_CFG 14'h0004
`define PF_VEC_LVL_B 14'h0008
`define PF_VEC_LVL_A 14'h000C
`define PF_VEC_EDGE 14'h0018
`define PF_VEC_SP_B 14'h0020
`define PF_VEC_SP_A 14'h0024

`endif

// ==== rtl/dsp_pin_function_select.sv ====
// pin function selection: straps, shared flag/irq pins, serial alt, bus
// assumes one 40 MHz clock, sync reset, pads resolved outside from oe
//
// Functional notes
// - external bus mode fixed only during reset
// - serial pin function changeable while running
// - flag and interrupt sensing active together
// - flag 7 interrupt edge or level
// - flags 6 and 5 interrupts level only
// - flag 4 interrupt edge only
// - mode straps sampled only during reset
// - strap pins become flags 0-3 after reset
// - enabled shared interrupt vectors on assertion
// - control bit picks serial or irq/flag use
// - strap C low full memory, high host
// - mode gates host port or byte transfers
// - full mode drives 14-bit shared address
// - byte access puts page on top data bits
// - bus request answered by grant and held
// - core halts while granted unless go mode
// - host mode keeps address bit 0, selects
`timescale 1ns/1ps
`default_nettype none
`include "pinfn_regs.svh"

module dsp_pin_function_select (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [7:0] i_prog_flag_i,
   output logic [7:0] o_prog_flag_o,
   output logic [7:0] o_prog_flag_oe,
   input wire logic [4:0] i_serial_pin_i,
   output logic [4:0] o_serial_pin_o,
   output logic [4:0] o_serial_pin_oe,
   input wire logic [4:0] i_sport_o,
   input wire logic [4:0] i_sport_oe,
   output logic [4:0] o_sport_i,
   output logic [5:0] o_irq_request,
   output logic o_vector_valid,
   output logic [13:0] o_vector_addr,
   input wire logic i_vector_ack,
   output logic [3:0] o_mode_strap,
   output logic o_host_mode,
   output logic o_host_memory_port_en,
   output logic o_byte_memory_transfer_en,
   input wire logic i_bus_request_n,
   output logic o_bus_grant_n,
   output logic o_bus_grant_held_n,
   output logic o_core_halt,
   input wire logic i_mem_req,
   input wire logic i_mem_write,
   input wire logic [1:0] i_mem_space,
   input wire logic [13:0] i_mem_addr,
   input wire logic [7:0] i_mem_byte_page,
   input wire logic [23:0] i_mem_wdata,
   output logic o_mem_done,
   output logic o_mem_refused,
   output logic [23:0] o_mem_rdata,
   output logic [13:0] o_ext_address_out,
   output logic [13:0] o_ext_address_oe,
   input wire logic [23:0] i_ext_data_bus_i,
   output logic [23:0] o_ext_data_bus_o,
   output logic [23:0] o_ext_data_bus_oe,
   output logic o_program_space_select_n,
   output logic o_data_space_select_n,
   output logic o_io_space_select_n,
   output logic o_byte_space_select_n,
   output logic o_combined_space_select_n,
   output logic o_mem_read_n,
   output logic o_mem_write_n
);

   ////////////////////////////////////////

   pinfn_pkg::pin_state_type st_q;
   pinfn_pkg::pin_state_type st_d;
   pinfn_pkg::space_type space;

   logic [7:0] level;
   logic [5:0] irq_pin_n;
   logic [5:0] irq_edge;
   logic [5:0] irq_clr;
   logic [5:0] raw_req;
   logic [5:0] alt_gate;
   logic [5:0] pend;
   logic [5:0] pend_clr;
   logic [5:0] ack_clr;
   logic [31:0] rd_word;
   logic [2:0] pick;
   logic reg_hit;
   logic apb_wr;
   logic alt;
   logic host;
   logic take;

   assign space = pinfn_pkg::space_type'(i_mem_space);
   assign alt = st_q.ctrl[`PF_CTRL_SP_ALT];
   assign host = st_q.strap[`PF_STRAP_C];
   assign apb_wr = i_psel & i_penable & i_pwrite;

   ////////////////////////////////////////
   // flags 0-3 carry the straps in reset, then serve as flags

   flag_port #(
      .WIDTH(8)
   ) u_flags (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_dir(st_q.dir),
      .i_val(st_q.outv[7:0]),
      .i_pin_i(i_prog_flag_i),
      .o_pin_o(o_prog_flag_o),
      .o_pin_oe(o_prog_flag_oe),
      .o_level(level)
   );

   ////////////////////////////////////////
   // sensing reads the pad, so a flag we drive raises its own irq

   assign irq_pin_n = {i_serial_pin_i[`PF_SP_IRQ_A],
                       i_serial_pin_i[`PF_SP_IRQ_B],
                       i_prog_flag_i[4],
                       i_prog_flag_i[5],
                       i_prog_flag_i[6],
                       i_prog_flag_i[7]};
   assign irq_edge = {st_q.ctrl[`PF_CTRL_SPA_EDGE],
                      st_q.ctrl[`PF_CTRL_SPB_EDGE],
                      1'b1,
                      1'b0,
                      1'b0,
                      st_q.ctrl[`PF_CTRL_IRQC_EDGE]};
   assign alt_gate = {alt, alt, 4'hF};
   assign pend_clr = (apb_wr && i_paddr == `PF_PEND_OFF) ? i_pwdata[5:0] : 6'h00;
   assign ack_clr = (i_vector_ack && st_q.vec_valid) ? (6'h01 << st_q.vec_idx) : 6'h00;
   assign irq_clr = pend_clr | ack_clr;

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_irq
         irq_sense u_sense (
            .i_ref_clk(i_ref_clk),
            .i_rst(i_rst),
            .i_pin_n(irq_pin_n[gi]),
            .i_edge_mode(irq_edge[gi]),
            .i_clear(irq_clr[gi]),
            .o_request(raw_req[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////

   assign take = i_mem_req && !st_q.acc && !st_q.done && i_bus_request_n
                 && st_q.bus == pinfn_pkg::BUS_OWN;

   always_comb begin
      st_d = st_q;
      rd_word = 32'h0;
      reg_hit = 1'b1;
      pend = raw_req & alt_gate & st_q.mask;
      pick = 3'h0;

      // register reads
      case (i_paddr)
         `PF_CTRL_OFF: rd_word = {27'h0, st_q.ctrl};
         `PF_DIR_OFF: rd_word = {24'h0, st_q.dir};
         `PF_OUT_OFF: rd_word = {23'h0, st_q.outv};
         `PF_PIN_OFF: rd_word = {23'h0, st_q.fi, level};
         `PF_MASK_OFF: rd_word = {26'h0, st_q.mask};
         `PF_PEND_OFF: rd_word = {26'h0, st_q.irq};
         `PF_MODE_OFF: rd_word = {27'h0, host, st_q.strap};
         `PF_BUS_OFF: rd_word = {29'h0, o_core_halt,
                                 !o_bus_grant_held_n, !o_bus_grant_n};
         default: reg_hit = 1'b0;
      endcase
      if (i_psel && !i_penable) begin
         st_d.prdata = rd_word;
      end

      // register writes; mode and status are read only
      if (apb_wr) begin
         case (i_paddr)
            `PF_CTRL_OFF: st_d.ctrl = i_pwdata[4:0];
            `PF_DIR_OFF: st_d.dir = i_pwdata[7:0];
            `PF_OUT_OFF: st_d.outv = i_pwdata[8:0];
            `PF_MASK_OFF: st_d.mask = i_pwdata[5:0];
            default: st_d.mask = st_q.mask;
         endcase
      end

      // priority pick, index 0 highest
      for (int i = 5; i >= 0; i--) begin
         if (pend[i]) begin
            pick = 3'(i);
         end
      end
      st_d.irq = raw_req & alt_gate;
      // hide the acked vector for the cycle its latch clears
      st_d.vec_valid = (|pend) && !(i_vector_ack && st_q.vec_valid);
      st_d.vec_idx = pick;
      case (pick)
         3'h0: st_d.vec_addr = `PF_VEC_CFG;
         3'h1: st_d.vec_addr = `PF_VEC_LVL_B;
         3'h2: st_d.vec_addr = `PF_VEC_LVL_A;
         3'h3: st_d.vec_addr = `PF_VEC_EDGE;
         3'h4: st_d.vec_addr = `PF_VEC_SP_B;
         3'h5: st_d.vec_addr = `PF_VEC_SP_A;
         default: st_d.vec_addr = `PF_VEC_CFG;
      endcase

      // serial pins: clock stays serial in the alternate use
      st_d.fi = alt & i_serial_pin_i[`PF_SP_FLAG_IN];
      if (alt) begin
         st_d.sp_o = 5'h00;
         st_d.sp_oe = 5'h00;
         st_d.sp_o[`PF_SP_FLAG_OUT] = st_q.outv[`PF_OUT_SP_FLAG];
         st_d.sp_oe[`PF_SP_FLAG_OUT] = 1'b1;
         st_d.sp_o[`PF_SP_CLK] = i_sport_o[`PF_SP_CLK];
         st_d.sp_oe[`PF_SP_CLK] = i_sport_oe[`PF_SP_CLK];
         st_d.sp_in = 5'h00;
         st_d.sp_in[`PF_SP_CLK] = i_serial_pin_i[`PF_SP_CLK];
      end else begin
         st_d.sp_o = i_sport_o;
         st_d.sp_oe = i_sport_oe;
         st_d.sp_in = i_serial_pin_i;
      end

      // bus arbitration
      case (st_q.bus)
         pinfn_pkg::BUS_OWN: begin
            if (!i_bus_request_n) begin
               st_d.bus = st_q.acc ? pinfn_pkg::BUS_WAIT : pinfn_pkg::BUS_GRANTED;
            end
         end
         pinfn_pkg::BUS_WAIT: begin
            if (i_bus_request_n) begin
               st_d.bus = pinfn_pkg::BUS_OWN;
            end else if (!st_q.acc) begin
               st_d.bus = pinfn_pkg::BUS_GRANTED;
            end
         end
         pinfn_pkg::BUS_GRANTED: begin
            if (i_bus_request_n) begin
               st_d.bus = pinfn_pkg::BUS_RELEASE;
            end
         end
         pinfn_pkg::BUS_RELEASE: begin
            st_d.bus = pinfn_pkg::BUS_OWN;
         end
         default: begin
            st_d.bus = pinfn_pkg::BUS_OWN;
         end
      endcase

      // external access: one strobe cycle, then a done pulse
      st_d.done = 1'b0;
      st_d.refused = 1'b0;
      if (st_q.acc) begin
         st_d.acc = 1'b0;
         st_d.done = 1'b1;
         st_d.rdata = host ? {i_ext_data_bus_i[23:8], 8'h00} : i_ext_data_bus_i;
         st_d.sel_n = `PF_SEL_IDLE;
         st_d.rd_n = 1'b1;
         st_d.wr_n = 1'b1;
         st_d.doe = 24'h000000;
      end else if (take) begin
         if (host && space == pinfn_pkg::SPACE_BYTE) begin
            // no byte space behind the host port
            st_d.done = 1'b1;
            st_d.refused = 1'b1;
         end else begin
            st_d.acc = 1'b1;
            st_d.rd_n = i_mem_write;
            st_d.wr_n = !i_mem_write;
            st_d.addr = host ? {13'h0000, i_mem_addr[0]} : i_mem_addr;
            case (space)
               pinfn_pkg::SPACE_PROG: begin
                  st_d.sel_n[`PF_SEL_PROG] = 1'b0;
                  st_d.sel_n[`PF_SEL_COMB] = 1'b0;
               end
               pinfn_pkg::SPACE_DATA: begin
                  st_d.sel_n[`PF_SEL_DATA] = 1'b0;
                  st_d.sel_n[`PF_SEL_COMB] = 1'b0;
               end
               pinfn_pkg::SPACE_IO: st_d.sel_n[`PF_SEL_IO] = 1'b0;
               default: st_d.sel_n[`PF_SEL_BYTE] = 1'b0;
            endcase
            if (space == pinfn_pkg::SPACE_BYTE) begin
               st_d.dout = {i_mem_byte_page, i_mem_wdata[15:0]};
               st_d.doe = i_mem_write ? `PF_DOE_ALL : `PF_DOE_PAGE;
            end else begin
               st_d.dout = i_mem_wdata;
               if (!i_mem_write) begin
                  st_d.doe = 24'h000000;
               end else begin
                  st_d.doe = host ? `PF_DOE_HOST : `PF_DOE_ALL;
               end
            end
         end
      end

      // address pads follow the mode while we own the bus
      if (st_d.bus == pinfn_pkg::BUS_OWN || st_d.bus == pinfn_pkg::BUS_WAIT) begin
         st_d.addr_oe = host ? `PF_AOE_HOST : `PF_AOE_FULL;
      end else begin
         st_d.addr_oe = 14'h0000;
         st_d.doe = 24'h000000;
      end

      // sync reset; straps caught on every clock edge while reset is high
      if (i_rst) begin
         st_d = '0;
         st_d.ctrl = `PF_CTRL_RST;
         st_d.dir = `PF_DIR_RST;
         st_d.outv = `PF_OUT_RST;
         st_d.mask = `PF_MASK_RST;
         st_d.bus = pinfn_pkg::BUS_OWN;
         st_d.sel_n = `PF_SEL_IDLE;
         st_d.rd_n = 1'b1;
         st_d.wr_n = 1'b1;
         st_d.strap = i_prog_flag_i[3:0];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      st_q <= st_d;
   end

   ////////////////////////////////////////

   assign o_prdata = st_q.prdata;
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel & i_penable & !reg_hit;

   assign o_serial_pin_o = st_q.sp_o;
   assign o_serial_pin_oe = st_q.sp_oe;
   assign o_sport_i = st_q.sp_in;

   assign o_irq_request = st_q.irq & st_q.mask;
   assign o_vector_valid = st_q.vec_valid;
   assign o_vector_addr = st_q.vec_addr;

   assign o_mode_strap = st_q.strap;
   assign o_host_mode = host;
   assign o_host_memory_port_en = host;
   assign o_byte_memory_transfer_en = !host;

   assign o_bus_grant_n = st_q.bus != pinfn_pkg::BUS_GRANTED;
   assign o_bus_grant_held_n = st_q.bus != pinfn_pkg::BUS_WAIT;
   // go mode keeps running from on-chip memory only
   assign o_core_halt = (st_q.bus == pinfn_pkg::BUS_GRANTED)
                        && !st_q.ctrl[`PF_CTRL_GO];

   assign o_mem_done = st_q.done;
   assign o_mem_refused = st_q.refused;
   assign o_mem_rdata = st_q.rdata;
   assign o_ext_address_out = st_q.addr;
   assign o_ext_address_oe = st_q.addr_oe;
   assign o_ext_data_bus_o = st_q.dout;
   assign o_ext_data_bus_oe = st_q.doe;
   assign o_program_space_select_n = st_q.sel_n[`PF_SEL_PROG];
   assign o_data_space_select_n = st_q.sel_n[`PF_SEL_DATA];
   assign o_io_space_select_n = st_q.sel_n[`PF_SEL_IO];
   assign o_byte_space_select_n = st_q.sel_n[`PF_SEL_BYTE];
   assign o_combined_space_select_n = st_q.sel_n[`PF_SEL_COMB];
   assign o_mem_read_n = st_q.rd_n;
   assign o_mem_write_n = st_q.wr_n;

endmodule

`default_nettype wire

// ==== rtl/flag_port.sv ====
// programmable flag pads: direction, drive value, sampled level
// assumes pad resolution outside; oe high while driving
`timescale 1ns/1ps
`default_nettype none

module flag_port #(
   parameter int WIDTH = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_dir,
   input wire logic [WIDTH-1:0] i_val,
   input wire logic [WIDTH-1:0] i_pin_i,
   output logic [WIDTH-1:0] o_pin_o,
   output logic [WIDTH-1:0] o_pin_oe,
   output logic [WIDTH-1:0] o_level
);

   typedef struct packed {
      logic [WIDTH-1:0] drv;
      logic [WIDTH-1:0] oe;
      logic [WIDTH-1:0] level;
   } port_type;

   port_type st_q;
   port_type st_d;

   always_comb begin
      st_d.drv = i_val & i_dir;
      st_d.oe = i_dir;
      st_d.level = i_pin_i;
      // pads float in reset so strap levels reach the sampler
      if (i_rst) begin
         st_d.drv = '0;
         st_d.oe = '0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      st_q <= st_d;
   end

   assign o_pin_o = st_q.drv;
   assign o_pin_oe = st_q.oe;
   assign o_level = st_q.level;

endmodule

`default_nettype wire

// ==== rtl/irq_sense.sv ====
// one active-low interrupt input, edge latch or plain level
// assumes pad level synchronous
`timescale 1ns/1ps
`default_nettype none

module irq_sense (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_pin_n,
   input wire logic i_edge_mode,
   input wire logic i_clear,
   output logic o_request
);

   typedef struct packed {
      logic prev_n;
      logic latch;
   } sense_type;

   sense_type st_q;
   sense_type st_d;

   always_comb begin
      st_d = st_q;
      st_d.prev_n = i_pin_n;
      if (i_clear) begin
         st_d.latch = 1'b0;
      end
      // a falling edge in the clear cycle is kept
      if (st_q.prev_n && !i_pin_n) begin
         st_d.latch = 1'b1;
      end
      if (i_rst) begin
         st_d.prev_n = 1'b1;
         st_d.latch = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      st_q <= st_d;
   end

   assign o_request = i_edge_mode ? st_q.latch : !i_pin_n;

endmodule

`default_nettype wire

// ==== test/ext_mem_model.sv ====
// far-side external memory
// assumes low strobes, bench resolves data
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
   input wire logic i_ref_clk,
   input wire logic [13:0] i_addr,
   input wire logic [23:0] i_data,
   input wire logic i_read_n,
   input wire logic i_write_n,
   output logic [23:0] o_data
);
   logic [23:0] mem_q [0:15];
   logic [23:0] last_q = 24'h0;
   always @(posedge i_ref_clk) begin
      if (!i_write_n) begin
         mem_q[i_addr[3:0]] <= i_data;
      end
      last_q <= o_data;
   end
   // released bus shows inverse: stale samples show
   assign o_data = !i_read_n ? mem_q[i_addr[3:0]] : ~last_q;
endmodule
`default_nettype wire

// ==== test/pin_fn_asserts.sv ====
// port checker, pin function block
// assumes bind to top, one clock
`timescale 1ns/1ps
`default_nettype none
module pin_fn_checker (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_bus_request_n,
   input wire logic [3:0] o_mode_strap,
   input wire logic o_host_mode,
   input wire logic o_host_memory_port_en,
   input wire logic o_byte_memory_transfer_en,
   input wire logic o_program_space_select_n,
   input wire logic o_byte_space_select_n,
   input wire logic [13:0] o_ext_address_oe,
   input wire logic [23:0] o_ext_data_bus_oe,
   input wire logic o_bus_grant_n,
   input wire logic o_core_halt,
   input wire logic [5:0] o_irq_request,
   input wire logic o_vector_valid,
   input wire logic [13:0] o_vector_addr
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////
   a_strap_hold: assert property (!$past(i_rst) |-> $stable(o_mode_strap))
      else $error("straps moved");
   a_mode_ties: assert property ((o_host_mode == o_mode_strap[2])
      && (o_host_memory_port_en == o_host_mode) && (o_byte_memory_transfer_en != o_host_mode))
      else $error("mode outputs wrong");
   a_full_addr: assert property (!o_host_mode && !o_program_space_select_n
      |-> o_ext_address_oe == 14'h3FFF) else $error("full address not driven");
   a_host_addr: assert property (o_host_mode && !o_program_space_select_n
      |-> o_ext_address_oe == 14'h1) else $error("host address bits wrong");
   a_byte_page: assert property (!o_byte_space_select_n
      |-> o_ext_data_bus_oe[23:16] == 8'hFF) else $error("page bits not driven");
   a_grant_answer: assert property ($fell(i_bus_request_n)
      |-> ##[1:8] (!o_bus_grant_n || i_bus_request_n)) else $error("grant too late");
   a_grant_hold: assert property (!o_bus_grant_n && !$past(o_bus_grant_n)
      |-> !$past(i_bus_request_n)) else $error("grant without request");
   a_grant_float: assert property (!o_bus_grant_n |-> o_ext_address_oe == 14'h0)
      else $error("address driven in grant");
   a_halt_grant: assert property (o_core_halt |-> !o_bus_grant_n)
      else $error("halt without grant");
   a_edge_vec: assert property (o_vector_valid && o_irq_request[3:0] == 4'h8
      |-> o_vector_addr == 14'h18) else $error("edge vector wrong");
   a_level_vec: assert property (o_vector_valid && o_irq_request[1:0] == 2'h2
      |-> o_vector_addr == 14'h8) else $error("level vector wrong");
endmodule
bind dsp_pin_function_select pin_fn_checker chk (.*);
`default_nettype wire

// ==== test/tb_top.sv ====
// bench: apb, pads, memory, bus request
// assumes memory model and bound checker
`timescale 1ns/1ps
`default_nettype none
`include "pinfn_regs.svh"
module tb_top;
   logic i_ref_clk = 1'b0;
   logic i_rst, i_psel, i_penable, i_pwrite, i_vector_ack, i_bus_request_n, i_mem_req;
   logic i_mem_write, o_pready, o_pslverr, o_vector_valid, o_host_mode, o_host_memory_port_en;
   logic o_byte_memory_transfer_en, o_bus_grant_n, o_bus_grant_held_n, o_core_halt;
   logic o_mem_done, o_mem_refused, errv, srf, o_mem_read_n, o_mem_write_n;
   logic o_program_space_select_n, o_data_space_select_n, o_io_space_select_n;
   logic o_byte_space_select_n, o_combined_space_select_n;
   logic [7:0] i_paddr, i_prog_flag_i, o_prog_flag_o, o_prog_flag_oe, i_mem_byte_page, flag_ext;
   logic [31:0] i_pwdata, o_prdata, rdv;
   logic [4:0] i_serial_pin_i, o_serial_pin_o, o_serial_pin_oe, i_sport_o, i_sport_oe;
   logic [4:0] o_sport_i, ser_ext;
   logic [5:0] o_irq_request;
   logic [13:0] o_vector_addr, i_mem_addr, o_ext_address_out, o_ext_address_oe, sa, soe;
   logic [3:0] o_mode_strap;
   logic [1:0] i_mem_space;
   logic [23:0] i_mem_wdata, o_mem_rdata, i_ext_data_bus_i, o_ext_data_bus_o;
   logic [23:0] o_ext_data_bus_oe, mem_d, sd;
   int n_fail = 0;
   int checks_done = 0;
   // pads resolved from enables
   assign i_prog_flag_i = (o_prog_flag_oe & o_prog_flag_o) | (~o_prog_flag_oe & flag_ext);
   assign i_serial_pin_i = (o_serial_pin_oe & o_serial_pin_o) | (~o_serial_pin_oe & ser_ext);
   assign i_ext_data_bus_i = (o_ext_data_bus_oe & o_ext_data_bus_o) | (~o_ext_data_bus_oe & mem_d);
   always #12.5 i_ref_clk = ~i_ref_clk;
   dsp_pin_function_select dut (.*);
   ext_mem_model model (.i_ref_clk(i_ref_clk), .i_addr(o_ext_address_out),
      .i_data(o_ext_data_bus_o), .i_read_n(o_mem_read_n), .i_write_n(o_mem_write_n),
      .o_data(mem_d));
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      do @(posedge i_ref_clk); while (o_pready !== 1'b1);
      rdv = o_prdata;
      errv = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_ref_clk);
   endtask
   task automatic mem(input logic wr, input logic [1:0] sp, input logic [13:0] a,
      input logic [23:0] d);
      i_mem_req <= 1'b1;
      i_mem_write <= wr;
      i_mem_space <= sp;
      i_mem_addr <= a;
      i_mem_wdata <= d;
      soe = 14'h0;
      do begin
         @(posedge i_ref_clk);
         if (o_mem_read_n === 1'b0 || o_mem_write_n === 1'b0) begin
            sa = o_ext_address_out;
            soe = o_ext_address_oe;
            sd = o_ext_data_bus_o;
         end
      end while (o_mem_done !== 1'b1);
      srf = o_mem_refused;
      i_mem_req <= 1'b0;
      @(posedge i_ref_clk);
   endtask
   // straps flip after release: late sampling shows
   task automatic do_reset(input logic [3:0] s);
      flag_ext <= {4'hF, s};
      i_rst <= 1'b1;
      tick(8);
      i_rst <= 1'b0;
      @(posedge i_ref_clk);
      flag_ext <= {4'hF, ~s};
   endtask
   task automatic ack();
      i_vector_ack <= 1'b1;
      @(posedge i_ref_clk);
      i_vector_ack <= 1'b0;
      tick(3);
   endtask
   task automatic give_verdict();
      if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      tick(5000);
      n_fail++;
      give_verdict();
   end
   initial begin
      {i_rst, i_psel, i_penable, i_pwrite, i_vector_ack, i_mem_req, i_mem_write} = 7'h40;
      i_bus_request_n = 1'b1;
      {i_paddr, i_pwdata, i_mem_space, i_mem_addr, i_mem_wdata} = '0;
      i_mem_byte_page = 8'h5A;
      flag_ext = 8'hFF;
      ser_ext = 5'h1F;
      i_sport_o = 5'h15;
      i_sport_oe = 5'h1F;
      @(posedge i_ref_clk);
      do_reset(4'hA);
      tick(3);
      chk("strap", 32'hA, o_mode_strap);
      chk("host", 32'h0, o_host_mode);
      chk("byte xfer", 32'h1, o_byte_memory_transfer_en);
      apb(1'b1, `PF_MODE_OFF, 32'h0);
      apb(1'b0, `PF_MODE_OFF, 32'h0);
      chk("mode reg", 32'h0A, rdv);
      apb(1'b0, `PF_CTRL_OFF, 32'h0);
      chk("ctrl reg", 32'h0, rdv);
      chk("serial out", 32'h15, o_serial_pin_o);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h1, errv);
      apb(1'b1, `PF_OUT_OFF, 32'h5);
      apb(1'b1, `PF_DIR_OFF, 32'h0F);
      tick(2);
      chk("flag oe", 32'h0F, o_prog_flag_oe);
      apb(1'b0, `PF_PIN_OFF, 32'h0);
      chk("flag pins", 32'hF5, rdv);
      apb(1'b1, `PF_MASK_OFF, 32'h3F);
      for (int i = 5; i < 7; i++) begin
         flag_ext <= flag_ext & ~(8'h01 << i);
         tick(4);
         chk("level req", 32'h1, o_irq_request[7-i]);
         chk("level vec", (i == 6) ? 32'h8 : 32'hC, o_vector_addr);
         flag_ext <= flag_ext | (8'h01 << i);
         tick(4);
         chk("level drop", 32'h0, o_irq_request[7-i]);
      end
      flag_ext[4] <= 1'b0;
      tick(4);
      flag_ext[4] <= 1'b1;
      tick(3);
      chk("edge latch", 32'h1, o_irq_request[3]);
      chk("edge vec", 32'h18, o_vector_addr);
      ack();
      chk("edge clear", 32'h0, o_irq_request[3]);
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, `PF_CTRL_OFF, m);
         flag_ext[7] <= 1'b0;
         tick(4);
         flag_ext[7] <= 1'b1;
         tick(4);
         chk("cfg req", m, o_irq_request[0]);
         apb(1'b1, `PF_PEND_OFF, 32'h1);
      end
      apb(1'b1, `PF_CTRL_OFF, 32'h0);
      // own flag pulls shared pin low
      apb(1'b1, `PF_DIR_OFF, 32'h1F);
      tick(5);
      chk("own flag irq", 32'h1, o_irq_request[3]);
      chk("vec valid", 32'h1, o_vector_valid);
      chk("own vec", 32'h18, o_vector_addr);
      ack();
      apb(1'b1, `PF_DIR_OFF, 32'h0F);
      apb(1'b1, `PF_OUT_OFF, 32'h105);
      apb(1'b1, `PF_CTRL_OFF, 32'h2);
      ser_ext[0] <= 1'b0;
      tick(4);
      chk("serial irq", 32'h1, o_irq_request[5]);
      chk("serial flag", 32'h1, o_serial_pin_o[3]);
      chk("sport in", 32'h10, o_sport_i);
      apb(1'b1, `PF_CTRL_OFF, 32'h0);
      tick(3);
      chk("serial irq off", 32'h0, o_irq_request[5]);
      chk("serial back", 32'h15, o_serial_pin_o);
      ser_ext[0] <= 1'b1;
      mem(1'b1, 2'h0, 14'h1234, 24'hABCDEF);
      chk("addr out", 32'h1234, sa);
      chk("addr oe", 32'h3FFF, soe);
      chk("data out", 32'hABCDEF, sd);
      mem(1'b0, 2'h0, 14'h1234, 24'h0);
      chk("read data", 32'hABCDEF, o_mem_rdata);
      mem(1'b1, 2'h2, 14'h7, 24'h1357);
      chk("page bits", 32'h5A1357, sd);
      for (int g = 0; g < 2; g++) begin
         apb(1'b1, `PF_CTRL_OFF, g << 2);
         i_bus_request_n <= 1'b0;
         tick(4);
         chk("grant", 32'h0, o_bus_grant_n);
         chk("halt", 1 - g, o_core_halt);
         chk("addr float", 32'h0, o_ext_address_oe);
         i_bus_request_n <= 1'b1;
         tick(4);
         chk("grant off", 32'h1, o_bus_grant_n);
      end
      do_reset(4'h4);
      tick(2);
      chk("host", 32'h1, o_host_mode);
      chk("host port", 32'h1, o_host_memory_port_en);
      mem(1'b1, 2'h2, 14'h7, 24'h1);
      chk("byte refused", 32'h1, srf);
      mem(1'b1, 2'h0, 14'h1, 24'h100);
      chk("host addr oe", 32'h1, soe);
      give_verdict();
   end
endmodule
`default_nettype wire
